// ==== include/vcr_defines.vh ====
// Purpose: constants for the virtual command response block
// Assumes: 64-bit registers reached over a plain strobe port, byte addresses
// Notes: none
//
// Summary of operation
// - whole response register reads zero when virtual command support is off
// - bit 0 is the in-flight flag, one while a command runs, resets to zero
// - command writes while the flag is set are dropped with no state change
// - bits 2:1 hold the completion code; 0 success, 1 undefined, codes 3-255 give 1
// - completion code 2 is command specific, code 3 never used
// - bits 63:8 hold the result, reset zero, zero for null, free, reserved
// - allocate returns pasid in 27:8 or code 2; free of invalid pasid gives code 2
// - bits 7:3 read as zero
// - a command write clears the response and sets the in-flight flag
// - command codes 0 null, 1 allocate, 2 free; free operand pasid in 27:8
`ifndef VCR_DEFINES_VH
`define VCR_DEFINES_VH
`define VCR_OFF_CMD 12'he10
`define VCR_OFF_RSP 12'he20
`define VCR_OFF_INT_STAT 12'he30
`define VCR_OFF_INT_MASK 12'he38
`define VCR_OFF_CTRL 12'he40
`define VCR_RSP_RESET 64'h0000000000000000
`define VCR_CMD_NULL 8'h00
`define VCR_CMD_ALLOC 8'h01
`define VCR_CMD_FREE 8'h02
`define VCR_CODE_OK 2'h0
`define VCR_CODE_UNDEF 2'h1
`define VCR_CODE_SPECIFIC 2'h2
`define VCR_PASID_LSB 8
`define VCR_PASID_MSB 27
`define VCR_EXEC_CYCLES 4'h2
`endif

// ==== hw/vcr_pasid_map.v ====
// Purpose: one bit per pasid, set while allocated
// Assumes: single clock, one operation per cycle
// Notes: lowest free pasid is found by a search; read data are registered
`timescale 1ns/100ps
`default_nettype none
module vcr_pasid_map #(
   parameter AW = 4
) (
   // clock and reset
   input wire mclk,
   input wire resetn,
   // operations
   input wire alloc_stb,
   input wire free_stb,
   input wire [AW-1:0] free_idx,
   // results, valid the cycle after a strobe
   output reg [AW-1:0] alloc_idx_q,
   output reg alloc_ok_q,
   output reg free_ok_q
);
   localparam N = 1 << AW;
   reg [N-1:0] used_q;
   reg [AW-1:0] first_free;
   reg any_free;
   integer i;

   always @* begin
      first_free = {AW{1'b0}};
      any_free = 1'b0;
      for (i = N - 1; i >= 0; i = i - 1) begin
         if (!used_q[i]) begin
            first_free = i[AW-1:0];
            any_free = 1'b1;
         end
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         used_q <= {N{1'b0}};
         alloc_idx_q <= {AW{1'b0}};
         alloc_ok_q <= 1'b0;
         free_ok_q <= 1'b0;
      end else begin
         if (alloc_stb) begin
            alloc_ok_q <= any_free;
            alloc_idx_q <= first_free;
            if (any_free) begin
               used_q[first_free] <= 1'b1;
            end
         end
         if (free_stb) begin
            // freeing a pasid that was never handed out is an error
            free_ok_q <= used_q[free_idx];
            used_q[free_idx] <= 1'b0;
         end
      end
   end
endmodule // vcr_pasid_map
`default_nettype wire

// ==== hw/vcr_top.v ====
// Purpose: virtual command submission and response registers with interrupt
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: 64-bit registers; pasids above the map size are reported invalid
`timescale 1ns/100ps
`default_nettype none
`include "vcr_defines.vh"
module vcr_top #(
   parameter AW = 4,
   parameter [3:0] EXEC_CYCLES = `VCR_EXEC_CYCLES
) (
   // clock and reset
   input wire mclk,
   input wire resetn,
   // capability strap, level from the same clock domain
   input wire virtual_command_supported,
   // register port
   input wire [11:0] reg_addr,
   input wire [63:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [63:0] reg_rdata_q,
   // interrupt
   output wire irq
);
   localparam ST_IDLE = 2'h0;
   localparam ST_EXEC = 2'h1;
   localparam ST_WAIT = 2'h2;
   localparam ST_DONE = 2'h3;

   reg [1:0] state_q;
   reg [3:0] cnt_q;
   reg [7:0] cmd_q;
   reg [19:0] operand_q;
   reg in_flight_flag_q;
   reg [1:0] completion_code_q;
   reg [55:0] result_payload_q;
   reg [1:0] int_stat_q;
   reg [1:0] int_mask_q;
   reg feature_en_q;
   reg done_pulse_q;

   wire [AW-1:0] alloc_idx;
   wire alloc_ok;
   wire free_ok;
   wire cmd_wr;
   wire op_start;
   wire alloc_stb;
   wire free_stb;
   wire free_in_range;
   wire [63:0] rsp_word;

   // without virtual command support a command write is a no-op
   assign cmd_wr = reg_wr && (reg_addr == `VCR_OFF_CMD) && virtual_command_supported;
   assign op_start = (state_q == ST_EXEC) && (cnt_q == 4'h0);
   assign alloc_stb = op_start && (cmd_q == `VCR_CMD_ALLOC);
   assign free_in_range = (operand_q >> AW) == 20'h00000;
   assign free_stb = op_start && (cmd_q == `VCR_CMD_FREE) && free_in_range;

   vcr_pasid_map #(
      .AW(AW)
   ) u_map (
      .mclk(mclk),
      .resetn(resetn),
      .alloc_stb(alloc_stb),
      .free_stb(free_stb),
      .free_idx(operand_q[AW-1:0]),
      .alloc_idx_q(alloc_idx),
      .alloc_ok_q(alloc_ok),
      .free_ok_q(free_ok)
   );

   // command engine
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         cmd_q <= 8'h00;
         operand_q <= 20'h00000;
         in_flight_flag_q <= 1'b0;
         completion_code_q <= `VCR_CODE_OK;
         result_payload_q <= 56'h00000000000000;
         done_pulse_q <= 1'b0;
      end else begin
         done_pulse_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               // a write during a running command never reaches here
               if (cmd_wr && !in_flight_flag_q) begin
                  cmd_q <= reg_wdata[7:0];
                  operand_q <= reg_wdata[`VCR_PASID_MSB:`VCR_PASID_LSB];
                  in_flight_flag_q <= 1'b1;
                  completion_code_q <= `VCR_CODE_OK;
                  result_payload_q <= 56'h00000000000000;
                  cnt_q <= EXEC_CYCLES - 4'h1;
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;
               end else begin
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // map results are registered, so they settle here
               state_q <= ST_DONE;
               if (cmd_q == `VCR_CMD_NULL) begin
                  completion_code_q <= `VCR_CODE_OK;
               end else if (cmd_q == `VCR_CMD_ALLOC) begin
                  if (alloc_ok) begin
                     completion_code_q <= `VCR_CODE_OK;
                     result_payload_q <= {36'h000000000,
                        {(20 - AW){1'b0}}, alloc_idx};
                  end else begin
                     completion_code_q <= `VCR_CODE_SPECIFIC;
                  end
               end else if (cmd_q == `VCR_CMD_FREE) begin
                  if (free_in_range && free_ok) begin
                     completion_code_q <= `VCR_CODE_OK;
                  end else begin
                     completion_code_q <= `VCR_CODE_SPECIFIC;
                  end
               end else begin
                  completion_code_q <= `VCR_CODE_UNDEF;
               end
            end
            ST_DONE: begin
               // flag drops one cycle after the results settle
               in_flight_flag_q <= 1'b0;
               done_pulse_q <= 1'b1;
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // response word; code 3 is never produced
   assign rsp_word = virtual_command_supported ?
      {result_payload_q, 5'h00, completion_code_q, in_flight_flag_q} :
      `VCR_RSP_RESET;

   // interrupt status: bit0 command done, bit1 command failed
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         int_stat_q <= 2'h0;
         int_mask_q <= 2'h0;
         feature_en_q <= 1'b0;
      end else begin
         if (reg_wr && (reg_addr == `VCR_OFF_INT_MASK)) begin
            int_mask_q <= reg_wdata[1:0];
         end
         if (reg_wr && (reg_addr == `VCR_OFF_CTRL)) begin
            feature_en_q <= reg_wdata[0];
         end
         // set wins over a write-one clear in the same cycle
         int_stat_q <= (int_stat_q &
            ~((reg_wr && (reg_addr == `VCR_OFF_INT_STAT)) ? reg_wdata[1:0] : 2'h0)) |
            {done_pulse_q && (completion_code_q != `VCR_CODE_OK), done_pulse_q};
      end
   end

   assign irq = feature_en_q && ((int_stat_q & int_mask_q) != 2'h0);

   // read port
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q <= 64'h0000000000000000;
      end else if (reg_rd) begin
         if (reg_addr == `VCR_OFF_RSP) begin
            reg_rdata_q <= rsp_word;
         end else if (reg_addr == `VCR_OFF_CMD) begin
            reg_rdata_q <= virtual_command_supported ?
               {36'h000000000, operand_q, cmd_q} : 64'h0000000000000000;
         end else if (reg_addr == `VCR_OFF_INT_STAT) begin
            reg_rdata_q <= {62'h0, int_stat_q};
         end else if (reg_addr == `VCR_OFF_INT_MASK) begin
            reg_rdata_q <= {62'h0, int_mask_q};
         end else if (reg_addr == `VCR_OFF_CTRL) begin
            reg_rdata_q <= {63'h0, feature_en_q};
         end else begin
            reg_rdata_q <= 64'h0000000000000000;
         end
      end
   end
endmodule // vcr_top
`default_nettype wire

// ==== dv/vcr_monitor.sv ====
// Purpose: port checks for the command response block
// Assumes: one clock, resetn low active
// Notes: the in-flight state is seen only through response reads
`timescale 1ns/100ps
`default_nettype none
module vcr_monitor (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // strap and register port
   input wire logic virtual_command_supported,
   input wire logic [11:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [63:0] reg_rdata_q
);
   wire logic rr = reg_rd && reg_addr == 12'he20;
   wire logic cw = reg_wr && reg_addr == 12'he10 && virtual_command_supported;
   wire logic cr = reg_rd && reg_addr == 12'he10;
   wire logic [63:0] q = reg_rdata_q;
   logic [2:0] busy_q;
   wire logic idle = busy_q == 3'h0;
   // an accepted command keeps the flag up four cycles; writes then are dropped
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         busy_q <= 3'h0;
      end else if (cw && idle) begin
         busy_q <= 3'h4;
      end else if (!idle) begin
         busy_q <= busy_q - 3'h1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_absent_reads_zero: assert property (rr && !virtual_command_supported |=> q == 0)
      else $error("response not zero with feature off");
   a_write_sets_flag: assert property (cw && idle ##2 rr |=> q[0])
      else $error("flag low just after command");
   a_busy_drops_cmd: assert property (cw && idle ##2
      (cw && reg_wdata[7:0] != $past(reg_wdata[7:0], 2))
      ##2 cr |=> q[7:0] != $past(reg_wdata[7:0], 3))
      else $error("command taken while busy");
   a_code_three_unused: assert property (rr |=> q[2:1] != 2'h3)
      else $error("completion code 3 seen");
   a_undef_no_result: assert property (rr |=> q[2:1] != 2'h1 || q[63:8] == 0)
      else $error("result with undefined command");
   a_result_upper_zero: assert property (rr |=> q[63:28] == 0)
      else $error("result above bit 27");
   a_reserved_bits_zero: assert property (rr |=> q[7:3] == 0)
      else $error("reserved response bits set");
   a_busy_fields_clear: assert property (cw && idle ##2 rr |=> q[63:1] == 0)
      else $error("fields not clear while busy");
endmodule // vcr_monitor
`default_nettype wire

// ==== dv/test_virtual_command_response.sv ====
// Purpose: directed test of the command response block
// Assumes: read data stand the cycle after the read strobe
// Notes: default map of 16 pasids keeps exhaustion short
`timescale 1ns/100ps
`default_nettype none
`define CK(a,b) begin n_tests++; if ((a) !== (b)) begin errors++; \
   $display("ERROR %0t %h %h", $time, a, b); end end
module test_virtual_command_response;
   localparam [11:0] ca = 12'he10, ra = 12'he20;
   logic mclk = 0, resetn = 0, sup = 1, wr = 0, rd = 0;
   logic [11:0] addr = 0;
   logic [63:0] wd = 0, r;
   wire logic [63:0] rdata;
   wire logic irq;
   int errors = 0, n_tests = 0, cyc = 0;
   vcr_top dut (.mclk(mclk), .resetn(resetn), .virtual_command_supported(sup),
      .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdata),
      .irq(irq));
   initial begin
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         end_of_test;
      end
   end
   task automatic wrt(input [11:0] a, input [63:0] d);
      @(posedge mclk);
      addr <= a;
      wd <= d;
      wr <= 1;
      @(posedge mclk);
      wr <= 0;
   endtask
   task automatic rdt(input [11:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1;
      @(posedge mclk);
      rd <= 0;
      #1 r = rdata;
   endtask
   // polls are bounded so a stuck flag fails the compare
   task automatic fin(input [63:0] e);
      for (int k = 0; k < 20 && r[0]; k++) rdt(ra);
      `CK(r, e)
   endtask
   task automatic run(input [63:0] d, input [63:0] e);
      wrt(ca, d);
      rdt(ra);
      `CK(r[0], 1'b1)
      fin(e);
   endtask
   task t_reset;
      rdt(ra);
      `CK(r, 64'h0)
   endtask
   task t_cmds;
      run(64'h0, 64'h0);
      run(64'h1, 64'h0);
      run(64'h1, 64'h100);
      run(64'h2, 64'h0);
      run(64'h2, 64'h4);
      run(64'h1002, 64'h4);
      run(64'h3, 64'h2);
      run(64'hff, 64'h2);
      run(64'hab03, 64'h2);
      for (int i = 0; i < 15; i++) run(64'h1, 64'((i == 0 ? 0 : i + 1) << 8));
      run(64'h1, 64'h4);
      run(64'h502, 64'h0);
      run(64'h1, 64'h500);
   endtask
   task t_busy;
      wrt(ca, 64'h0);
      wrt(ca, 64'h3);
      rdt(ca);
      `CK(r[7:0], 8'h0)
      r = 1;
      fin(64'h0);
   endtask
   task t_irq;
      wrt(12'he38, 64'h3);
      #1 `CK(irq, 1'b0)
      wrt(12'he40, 64'h1);
      #1 `CK(irq, 1'b1)
      wrt(12'he30, 64'h3);
      #1 `CK(irq, 1'b0)
      wrt(12'he38, 64'h2);
      run(64'h0, 64'h0);
      `CK(irq, 1'b0)
      run(64'h7, 64'h2);
      `CK(irq, 1'b1)
      rdt(12'he30);
      `CK(r, 64'h3)
      wrt(12'he30, 64'h3);
      rdt(12'hf00);
      `CK(r, 64'h0)
   endtask
   task t_absent;
      sup <= 0;
      rdt(ra);
      `CK(r, 64'h0)
      wrt(ca, 64'h1);
      rdt(ra);
      `CK(r, 64'h0)
      sup <= 1;
      rdt(ra);
      `CK(r, 64'h2)
   endtask
   task end_of_test;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      resetn <= 1;
      t_reset;
      t_cmds;
      t_busy;
      t_irq;
      t_absent;
      resetn <= 0;
      repeat (2) @(posedge mclk);
      resetn <= 1;
      t_reset;
      end_of_test;
   end
endmodule // test_virtual_command_response
bind vcr_top vcr_monitor u_mon (.mclk(mclk), .resetn(resetn),
   .virtual_command_supported(virtual_command_supported), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
`default_nettype wire
